// *** src/pm_ctl_pkg.sv ***
// Constants for the power-management control register group.
// Assumes offsets are added to a base supplied by the configuration logic.
package pm_ctl_pkg;

  // ----------------------------------------------------------------
  // Register offsets from the programmable I/O base
  // ----------------------------------------------------------------
  localparam logic [15:0] OFF_CTL_ONE   = 16'h0004;
  localparam logic [15:0] OFF_CTL_THREE = 16'h0006;
  localparam logic [15:0] OFF_CTL_FOUR  = 16'h0007;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int          BIT_ROUTE_SELECT   = 0;
  localparam int          BIT_RELOAD_ENABLE  = 1;
  localparam int          BIT_GLOBAL_RELEASE = 2;
  localparam logic [7:0]  CTL_ONE_MASK       = 8'h07;
  localparam logic [7:0]  CTL_RESET          = 8'h00;
  localparam logic [7:0]  READ_ZERO          = 8'h00;

  // Decoded register select, one-hot
  typedef enum logic [1:0] {
    SEL_NONE  = 2'b00,
    SEL_ONE   = 2'b01,
    SEL_RSVD  = 2'b10
  } reg_sel_type;

endpackage

// *** src/pm_event_control_regs.sv ***
// Power-management control registers one, three and four in I/O space.
// Assumes one-cycle read and write strobes, synchronous to sys_clk.
`timescale 1ns/1ps

// Operation
// - Route select set sends every event to the control interrupt.
// - Route clear and path enabled send events to the mgmt interrupt.
// - Reload enable with bus-master control raises control interrupt.
// - Writing one to global release sets the firmware event status bit.
// - Firmware status with firmware enable raises the mgmt interrupt.
// - Register one bits 7:3 and registers three and four read zero.
// - Registers one, three, four sit at base plus 4, 6, 7; 8 bits, reset 0.
// - Bus-master control set also sets status; status clear drops both.
module pm_event_control_regs (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic [15:0] io_base,
  input  wire logic [15:0] io_addr,
  input  wire logic        io_rd,
  input  wire logic        io_wr,
  input  wire logic [7:0]  io_wdata,
  output logic      [7:0]  io_rdata,
  output logic             io_rd_ack,
  input  wire logic        pm_event,
  input  wire logic        mgmt_path_enable,
  input  wire logic        firmware_event_enable,
  input  wire logic        busmaster_control_set,
  input  wire logic        busmaster_status_clear,
  input  wire logic        firmware_status_clear,
  output logic             busmaster_control,
  output logic             busmaster_status,
  output logic             firmware_event_status,
  output logic             control_interrupt_out,
  output logic             mgmt_interrupt_out
);

  pm_status_if st ();

  logic [7:0]  ctl_one_q;
  logic [7:0]  ctl_one_d;
  logic [7:0]  rdata_q;
  logic [7:0]  rdata_d;
  logic        rd_ack_q;
  logic        rd_ack_d;
  logic        ctl_irq_q;
  logic        ctl_irq_d;
  logic        mgmt_irq_q;
  logic        mgmt_irq_d;
  logic        wr_one;
  pm_ctl_pkg::reg_sel_type rd_sel;
  pm_ctl_pkg::reg_sel_type wr_sel;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  function automatic pm_ctl_pkg::reg_sel_type decode(
    input logic [15:0] base,
    input logic [15:0] addr
  );
    logic [15:0] off;
    off = addr - base;
    // Offset wraps below base, so a low address is rejected before any compare
    if (addr < base) begin
      decode = pm_ctl_pkg::SEL_NONE;
    end else if (off == pm_ctl_pkg::OFF_CTL_ONE) begin
      decode = pm_ctl_pkg::SEL_ONE;
    end else if (off == pm_ctl_pkg::OFF_CTL_THREE) begin
      decode = pm_ctl_pkg::SEL_RSVD;
    end else if (off == pm_ctl_pkg::OFF_CTL_FOUR) begin
      decode = pm_ctl_pkg::SEL_RSVD;
    end else begin
      decode = pm_ctl_pkg::SEL_NONE;
    end
  endfunction

  assign rd_sel = decode(io_base, io_addr);
  assign wr_sel = decode(io_base, io_addr);
  assign wr_one = io_wr && (wr_sel == pm_ctl_pkg::SEL_ONE);

  // ----------------------------------------------------------------
  // Register one and side effects of its writes
  // ----------------------------------------------------------------
  always_comb begin
    ctl_one_d = ctl_one_q;
    if (wr_one) begin
      // Reserved positions never stored, so they keep reading zero
      ctl_one_d = io_wdata & pm_ctl_pkg::CTL_ONE_MASK;
    end
  end

  // Registers three and four hold nothing; writes there are dropped
  assign st.firmware_status_set =
    wr_one && io_wdata[pm_ctl_pkg::BIT_GLOBAL_RELEASE];
  assign st.busmaster_control_set  = busmaster_control_set;
  assign st.busmaster_status_clear = busmaster_status_clear;
  assign st.firmware_status_clear  = firmware_status_clear;

  pm_status_bits u_status (
    .sys_clk (sys_clk),
    .rst     (rst),
    .st      (st)
  );

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  always_comb begin
    rdata_d  = rdata_q;
    rd_ack_d = 1'b0;
    if (io_rd) begin
      if (rd_sel == pm_ctl_pkg::SEL_ONE) begin
        rdata_d  = ctl_one_q & pm_ctl_pkg::CTL_ONE_MASK;
        rd_ack_d = 1'b1;
      end else if (rd_sel == pm_ctl_pkg::SEL_RSVD) begin
        rdata_d  = pm_ctl_pkg::READ_ZERO;
        rd_ack_d = 1'b1;
      end else begin
        rdata_d  = pm_ctl_pkg::READ_ZERO;
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupt routing
  // ----------------------------------------------------------------
  // Outputs are registered, one cycle behind their causes
  always_comb begin
    ctl_irq_d  = 1'b0;
    mgmt_irq_d = 1'b0;
    if (pm_event) begin
      if (ctl_one_q[pm_ctl_pkg::BIT_ROUTE_SELECT]) begin
        ctl_irq_d = 1'b1;
      end else if (mgmt_path_enable) begin
        mgmt_irq_d = 1'b1;
      end
    end
    if (ctl_one_q[pm_ctl_pkg::BIT_RELOAD_ENABLE] && st.busmaster_control) begin
      ctl_irq_d = 1'b1;
    end
    if (st.firmware_event_status && firmware_event_enable) begin
      mgmt_irq_d = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctl_one_q  <= pm_ctl_pkg::CTL_RESET;
      rdata_q    <= pm_ctl_pkg::READ_ZERO;
      rd_ack_q   <= 1'b0;
      ctl_irq_q  <= 1'b0;
      mgmt_irq_q <= 1'b0;
    end else begin
      ctl_one_q  <= ctl_one_d;
      rdata_q    <= rdata_d;
      rd_ack_q   <= rd_ack_d;
      ctl_irq_q  <= ctl_irq_d;
      mgmt_irq_q <= mgmt_irq_d;
    end
  end

  assign io_rdata              = rdata_q;
  assign io_rd_ack             = rd_ack_q;
  assign busmaster_control     = st.busmaster_control;
  assign busmaster_status      = st.busmaster_status;
  assign firmware_event_status = st.firmware_event_status;
  assign control_interrupt_out = ctl_irq_q;
  assign mgmt_interrupt_out    = mgmt_irq_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  route_ctl_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    (pm_event && ctl_one_q[pm_ctl_pkg::BIT_ROUTE_SELECT])
      |=> control_interrupt_out)
    else $error("routed event missed the control interrupt");

  route_mgmt_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    (pm_event && !ctl_one_q[pm_ctl_pkg::BIT_ROUTE_SELECT] && mgmt_path_enable)
      |=> mgmt_interrupt_out)
    else $error("event missed the management interrupt");

  route_exclusive_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    (ctl_one_q[pm_ctl_pkg::BIT_ROUTE_SELECT]
      && !(st.firmware_event_status && firmware_event_enable))
      |=> !mgmt_interrupt_out)
    else $error("management interrupt while events go to control");

  reload_irq_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    (ctl_one_q[pm_ctl_pkg::BIT_RELOAD_ENABLE] && st.busmaster_control)
      |=> control_interrupt_out)
    else $error("reload did not raise the control interrupt");

  ctl_idle_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    (!pm_event && !(ctl_one_q[pm_ctl_pkg::BIT_RELOAD_ENABLE]
      && st.busmaster_control)) |=> !control_interrupt_out)
    else $error("control interrupt without cause");

  release_chain_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    (wr_one && io_wdata[pm_ctl_pkg::BIT_GLOBAL_RELEASE]
      && firmware_event_enable ##1 firmware_event_enable)
      |=> mgmt_interrupt_out)
    else $error("release did not reach the management interrupt");

  rsvd_read_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    (io_rd && rd_sel == pm_ctl_pkg::SEL_RSVD)
      |=> (io_rd_ack && io_rdata == 8'h00))
    else $error("reserved register read nonzero");

  ctl_write_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    wr_one |=> (ctl_one_q == ($past(io_wdata) & 8'h07)
      && ctl_one_q[7:3] == 5'h00))
    else $error("register one write stored wrong bits");

  ctl_reset_a: assert property (
    @(posedge sys_clk)
    rst |=> (ctl_one_q == 8'h00 && !control_interrupt_out
      && !mgmt_interrupt_out))
    else $error("register one not cleared by reset");

endmodule

// *** src/pm_status_bits.sv ***
// Sticky bus-master and firmware event status bits.
// Assumes set and clear requests are one-cycle pulses on sys_clk.
`timescale 1ns/1ps
module pm_status_bits (
  input  wire logic   sys_clk,
  input  wire logic   rst,
  pm_status_if.owner  st
);

  logic bm_ctl_q;
  logic bm_ctl_d;
  logic busmaster_status_q;
  logic busmaster_status_d;
  logic fw_sts_q;
  logic fw_sts_d;

  // ----------------------------------------------------------------
  // Next state: a set in the same cycle as a clear wins
  // ----------------------------------------------------------------
  always_comb begin
    bm_ctl_d = bm_ctl_q;
    busmaster_status_d = busmaster_status_q;
    fw_sts_d = fw_sts_q;
    if (st.busmaster_status_clear) begin
      bm_ctl_d = 1'b0;
      busmaster_status_d = 1'b0;
    end
    if (st.busmaster_control_set) begin
      bm_ctl_d = 1'b1;
      busmaster_status_d = 1'b1;
    end
    if (st.firmware_status_clear) begin
      fw_sts_d = 1'b0;
    end
    if (st.firmware_status_set) begin
      fw_sts_d = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      bm_ctl_q <= 1'b0;
      busmaster_status_q <= 1'b0;
      fw_sts_q <= 1'b0;
    end else begin
      bm_ctl_q <= bm_ctl_d;
      busmaster_status_q <= busmaster_status_d;
      fw_sts_q <= fw_sts_d;
    end
  end

  assign st.busmaster_control     = bm_ctl_q;
  assign st.busmaster_status      = busmaster_status_q;
  assign st.firmware_event_status = fw_sts_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  bm_set_both_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    st.busmaster_control_set |=> (bm_ctl_q && busmaster_status_q))
    else $error("bus-master write did not set control and status");

  bm_clear_both_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    (st.busmaster_status_clear && !st.busmaster_control_set)
      |=> (!bm_ctl_q && !busmaster_status_q))
    else $error("status clear left a bus-master bit set");

  fw_set_wins_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    st.firmware_status_set |=> fw_sts_q)
    else $error("firmware status not set by release");

  fw_clear_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    (st.firmware_status_clear && !st.firmware_status_set) |=> !fw_sts_q)
    else $error("firmware status not cleared");

endmodule

// *** src/pm_status_if.sv ***
// Carrier between the control register group and its status bits.
// Assumes both ends run on sys_clk.
`timescale 1ns/1ps
interface pm_status_if;
  logic busmaster_control_set;
  logic busmaster_status_clear;
  logic firmware_status_set;
  logic firmware_status_clear;
  logic busmaster_control;
  logic busmaster_status;
  logic firmware_event_status;

  modport owner (
    input  busmaster_control_set,
    input  busmaster_status_clear,
    input  firmware_status_set,
    input  firmware_status_clear,
    output busmaster_control,
    output busmaster_status,
    output firmware_event_status
  );

  modport user (
    output busmaster_control_set,
    output busmaster_status_clear,
    output firmware_status_set,
    output firmware_status_clear,
    input  busmaster_control,
    input  busmaster_status,
    input  firmware_event_status
  );
endinterface

// *** tb/io_host_model.sv ***
// Host side of the I/O port: one-cycle read and write strobes.
// Assumes the bench calls its tasks from a single process.
`timescale 1ns/1ps
module io_host_model (
  input  wire logic        sys_clk,
  input  wire logic [15:0] io_base,
  input  wire logic [7:0]  io_rdata,
  input  wire logic        io_rd_ack,
  output logic      [15:0] io_addr,
  output logic             io_rd,
  output logic             io_wr,
  output logic      [7:0]  io_wdata
);
  initial begin
    io_addr  = 16'hffff;
    io_rd    = 1'b0;
    io_wr    = 1'b0;
    io_wdata = 8'h00;
  end

  task automatic wr(input logic [15:0] off, input logic [7:0] d);
    @(posedge sys_clk);
    io_addr  <= io_base + off;
    io_wdata <= d;
    io_wr    <= 1'b1;
    @(posedge sys_clk);
    io_wr    <= 1'b0;
    // Released lines must not keep the last value
    io_wdata <= ~d;
    io_addr  <= ~(io_base + off);
  endtask

  task automatic rd(input logic [15:0] off, output logic [7:0] d,
                    output logic a);
    @(posedge sys_clk);
    io_addr <= io_base + off;
    io_rd   <= 1'b1;
    @(posedge sys_clk);
    io_rd   <= 1'b0;
    io_addr <= ~(io_base + off);
    #1;
    d = io_rdata;
    a = io_rd_ack;
  endtask
endmodule

// *** tb/pm_event_control_regs_tb.sv ***
// Self-checking bench for the power-management control registers.
// Assumes the design answers reads one cycle after the strobe.
`timescale 1ns/1ps
module pm_event_control_regs_tb;
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic [15:0] io_base = 16'h0290;
  logic [15:0] io_addr;
  logic        io_rd, io_wr, io_rd_ack;
  logic [7:0]  io_wdata, io_rdata, rdv;
  logic        pm_event = 1'b0, mgmt_path_enable = 1'b0;
  logic        firmware_event_enable = 1'b0, busmaster_control_set = 1'b0;
  logic        busmaster_status_clear = 1'b0, firmware_status_clear = 1'b0;
  logic        busmaster_control, busmaster_status, firmware_event_status;
  logic        control_interrupt_out, mgmt_interrupt_out, ack;
  int          err_count = 0;
  int          n_compared = 0;

  always #4 sys_clk = ~sys_clk;

  io_host_model u_host (.sys_clk(sys_clk), .io_base(io_base),
    .io_rdata(io_rdata), .io_rd_ack(io_rd_ack), .io_addr(io_addr),
    .io_rd(io_rd), .io_wr(io_wr), .io_wdata(io_wdata));

  pm_event_control_regs u_dut (.sys_clk(sys_clk), .rst(rst),
    .io_base(io_base), .io_addr(io_addr), .io_rd(io_rd), .io_wr(io_wr),
    .io_wdata(io_wdata), .io_rdata(io_rdata), .io_rd_ack(io_rd_ack),
    .pm_event(pm_event), .mgmt_path_enable(mgmt_path_enable),
    .firmware_event_enable(firmware_event_enable),
    .busmaster_control_set(busmaster_control_set),
    .busmaster_status_clear(busmaster_status_clear),
    .firmware_status_clear(firmware_status_clear),
    .busmaster_control(busmaster_control),
    .busmaster_status(busmaster_status),
    .firmware_event_status(firmware_event_status),
    .control_interrupt_out(control_interrupt_out),
    .mgmt_interrupt_out(mgmt_interrupt_out));

  // ----------------------------------------------------------------
  // Shared helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Order: control irq, mgmt irq, bm control, bm status, fw status
  task automatic chk_out(input logic [4:0] e);
    chk({3'h0, control_interrupt_out, mgmt_interrupt_out,
         busmaster_control, busmaster_status, firmware_event_status},
        {3'h0, e});
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic rd_chk(input logic [15:0] off, input logic [7:0] e,
                        input logic ea);
    u_host.rd(off, rdv, ack);
    chk(rdv, e);
    chk({7'h00, ack}, {7'h00, ea});
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic check_reset;
    rd_chk(16'h0004, 8'h00, 1'b1);
    rd_chk(16'h0006, 8'h00, 1'b1);
    rd_chk(16'h0007, 8'h00, 1'b1);
    rd_chk(16'h0005, 8'h00, 1'b0);
    chk_out(5'b00000);
  endtask

  task automatic check_reserved;
    u_host.wr(16'h0004, 8'hff);
    tick(3);
    rd_chk(16'h0004, 8'h07, 1'b1);
    chk_out(5'b00001);
    u_host.wr(16'h0006, 8'hff);
    u_host.wr(16'h0007, 8'hff);
    rd_chk(16'h0006, 8'h00, 1'b1);
    rd_chk(16'h0007, 8'h00, 1'b1);
    u_host.wr(16'h0004, 8'h00);
    @(posedge sys_clk) firmware_status_clear <= 1'b1;
    @(posedge sys_clk) firmware_status_clear <= 1'b0;
    tick(3);
    chk_out(5'b00000);
  endtask

  task automatic check_route;
    u_host.wr(16'h0004, 8'h01);
    @(posedge sys_clk);
    pm_event         <= 1'b1;
    mgmt_path_enable <= 1'b1;
    tick(3);
    chk_out(5'b10000);
    u_host.wr(16'h0004, 8'h00);
    tick(3);
    chk_out(5'b01000);
    @(posedge sys_clk) mgmt_path_enable <= 1'b0;
    tick(3);
    chk_out(5'b00000);
    @(posedge sys_clk) pm_event <= 1'b0;
  endtask

  task automatic check_reload;
    u_host.wr(16'h0004, 8'h02);
    @(posedge sys_clk) busmaster_control_set <= 1'b1;
    @(posedge sys_clk) busmaster_control_set <= 1'b0;
    tick(3);
    chk_out(5'b10110);
    u_host.wr(16'h0004, 8'h00);
    tick(3);
    chk_out(5'b00110);
    @(posedge sys_clk) busmaster_status_clear <= 1'b1;
    @(posedge sys_clk) busmaster_status_clear <= 1'b0;
    tick(3);
    chk_out(5'b00000);
    // Set and clear in one cycle: the set must win
    @(posedge sys_clk) begin
      busmaster_control_set  <= 1'b1;
      busmaster_status_clear <= 1'b1;
    end
    @(posedge sys_clk) begin
      busmaster_control_set  <= 1'b0;
      busmaster_status_clear <= 1'b0;
    end
    tick(3);
    chk_out(5'b00110);
    @(posedge sys_clk) busmaster_status_clear <= 1'b1;
    @(posedge sys_clk) busmaster_status_clear <= 1'b0;
    tick(3);
    chk_out(5'b00000);
  endtask

  task automatic check_release;
    @(posedge sys_clk) firmware_event_enable <= 1'b1;
    u_host.wr(16'h0004, 8'h04);
    tick(3);
    chk_out(5'b01001);
    @(posedge sys_clk) firmware_status_clear <= 1'b1;
    @(posedge sys_clk) firmware_status_clear <= 1'b0;
    tick(3);
    chk_out(5'b00000);
    // Release write and firmware clear in one cycle: the set must win
    fork
      u_host.wr(16'h0004, 8'h04);
      begin
        @(posedge sys_clk) firmware_status_clear <= 1'b1;
        @(posedge sys_clk) firmware_status_clear <= 1'b0;
      end
    join
    tick(3);
    chk_out(5'b01001);
    @(posedge sys_clk) firmware_status_clear <= 1'b1;
    @(posedge sys_clk) firmware_status_clear <= 1'b0;
    tick(3);
    chk_out(5'b00000);
    rd_chk(16'h0004, 8'h04, 1'b1);
    // Below the base nothing hits, and a miss clears the read data
    rd_chk(16'hfffc, 8'h00, 1'b0);
    rd_chk(16'h0004, 8'h04, 1'b1);
    rd_chk(16'h0005, 8'h00, 1'b0);
    // Reset in mid-run must bring the register back to zero
    @(posedge sys_clk) rst <= 1'b1;
    tick(2);
    @(posedge sys_clk) rst <= 1'b0;
    rd_chk(16'h0004, 8'h00, 1'b1);
  endtask

  task automatic finish_test;
    if (err_count == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    check_reset;
    check_reserved;
    check_route;
    check_reload;
    check_release;
    finish_test;
  end

  // Whole run is little more than a hundred cycles; the 5000-cycle limit leaves a wide margin
  initial begin
    #40000;
    err_count++;
    finish_test;
  end
endmodule
